// file: src/two_phase_quadrature_counter.sv
`timescale 1ns/1ps
// Functional notes
// R1: the count rises by one for A low/B rise, A rise/B high, A high/B fall, A fall/B low.
// R2: the count falls by one for A low/B fall, A rise/B low, A high/B rise, A fall/B high.
// R3: rising and falling edges on either phase are both valid edges.
// R4: each channel starts and captures on a valid edge of its own phase; here the width counter runs from reset and the first edge already captures.
// R5: the shared timer tick runs at about 9.77 kHz.
// R6: both channels take operation and counter clock from that one tick.
// R7: phase inputs pass a noise filter before edge detection.
// R8: channels measure pulse width and raise no capture event at start.
// R9: the encoder drives phase A on the first input and phase B on the second.
// R10: the timer logic is clocked by the core clock (20 MHz nominal); here TICK_DIV is sized for clk at CLK_HZ, 25 MHz.
// R11: each capture samples both levels and picks the action for the next edge.
// R12: the count spans sixty times four steps, wrapping at both ends.
module two_phase_quadrature_counter
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // encoder phases
  input wire logic phaseAInput,
  input wire logic phaseBInput,
  // control
  input wire logic enable,
  // capture events
  output logic channelZeroCaptureEvent,
  output logic channelOneCaptureEvent,
  // measured pulse widths in timer ticks
  output logic [15:0] widthA,
  output logic [15:0] widthB,
  // position
  output logic [quad_counter_pkg::POS_W-1:0] positionCount
);

  // -----------------------------------------------------------------
  // prescaled timer clock
  // -----------------------------------------------------------------
  localparam logic [11:0] DIV_LAST = 12'(quad_counter_pkg::TICK_DIV - 1);
  localparam logic [quad_counter_pkg::POS_W-1:0] POS_MAX =
    quad_counter_pkg::POS_W'(quad_counter_pkg::MAX_COUNT_LIMIT - 1);

  logic [11:0] div_r;
  wire prescaledTimerClock = (div_r == DIV_LAST); // R5 R6

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      div_r <= 12'h000;
    else if (prescaledTimerClock)
      div_r <= 12'h000;
    else
      div_r <= div_r + 12'h001;
  end

  // -----------------------------------------------------------------
  // noise filters
  // -----------------------------------------------------------------
  // filtering on the timer tick rejects glitches shorter than a few ticks
  logic levelA;
  logic levelB;

  phase_filter filtA
  (
    .clk(clk),
    .rstn(rstn),
    .tick(prescaledTimerClock),
    .rawIn(phaseAInput),
    .level(levelA)
  ); // R7 R9

  phase_filter filtB
  (
    .clk(clk),
    .rstn(rstn),
    .tick(prescaledTimerClock),
    .rawIn(phaseBInput),
    .level(levelB)
  ); // R7 R9

  // -----------------------------------------------------------------
  // edge detection and channel start
  // -----------------------------------------------------------------
  logic prevA_r;
  logic prevB_r;
  logic run_r;
  wire edgeA = (levelA != prevA_r); // R3
  wire edgeB = (levelB != prevB_r); // R3
  // no event at start: the first pass only arms the channels
  wire capA = run_r & enable & edgeA; // R4 R8
  wire capB = run_r & enable & edgeB; // R4 R8

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prevA_r <= 1'b0;
      prevB_r <= 1'b0;
      run_r <= 1'b0;
    end
    else
    begin
      prevA_r <= levelA;
      prevB_r <= levelB;
      run_r <= enable;
    end
  end

  // -----------------------------------------------------------------
  // pulse-width counters, one per channel
  // -----------------------------------------------------------------
  logic [15:0] cntA_r;
  logic [15:0] cntB_r;
  logic [15:0] widthA_r;
  logic [15:0] widthB_r;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cntA_r <= 16'h0000;
      widthA_r <= 16'h0000;
    end
    else if (capA)
    begin
      widthA_r <= cntA_r; // R4
      cntA_r <= 16'h0000;
    end
    else if (prescaledTimerClock && cntA_r != 16'hFFFF)
      cntA_r <= cntA_r + 16'h0001; // R6
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cntB_r <= 16'h0000;
      widthB_r <= 16'h0000;
    end
    else if (capB)
    begin
      widthB_r <= cntB_r; // R4
      cntB_r <= 16'h0000;
    end
    else if (prescaledTimerClock && cntB_r != 16'hFFFF)
      cntB_r <= cntB_r + 16'h0001; // R6
  end

  // -----------------------------------------------------------------
  // direction decode
  // -----------------------------------------------------------------
  // old and new level of phase A, then old and new level of phase B
  function automatic quad_counter_pkg::action_t decode
  (
    input logic aOld,
    input logic aNew,
    input logic bOld,
    input logic bNew
  );
    logic aE;
    logic bE;
    aE = aOld ^ aNew;
    bE = bOld ^ bNew;
    // a b edge counts up when the phases end unequal, an a edge when they end equal
    if (aE == bE)
      decode = quad_counter_pkg::ACT_HOLD;
    else if (bE)
      decode = (aNew ^ bNew) ? quad_counter_pkg::ACT_UP
                             : quad_counter_pkg::ACT_DOWN; // R1 R2
    else
      decode = (aNew ^ bNew) ? quad_counter_pkg::ACT_DOWN
                             : quad_counter_pkg::ACT_UP; // R1 R2
  endfunction

  // levels sampled at the last capture select the action for this edge
  logic sampA_r;
  logic sampB_r;
  wire anyCap = capA | capB;
  quad_counter_pkg::action_t act;
  assign act = anyCap ? decode(sampA_r, levelA, sampB_r, levelB)
                      : quad_counter_pkg::ACT_HOLD; // R11

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sampA_r <= 1'b0;
      sampB_r <= 1'b0;
    end
    else if (anyCap || !run_r)
    begin
      sampA_r <= levelA; // R11
      sampB_r <= levelB; // R11
    end
  end

  // -----------------------------------------------------------------
  // position counter
  // -----------------------------------------------------------------
  logic [quad_counter_pkg::POS_W-1:0] pos_r;
  logic [quad_counter_pkg::POS_W-1:0] pos_nxt;
  wire atMax = (pos_r == POS_MAX);
  wire atZero = (pos_r == quad_counter_pkg::POS_RESET);

  always_comb
  begin
    pos_nxt = pos_r;
    unique case (act)
      quad_counter_pkg::ACT_UP:
        pos_nxt = atMax ? quad_counter_pkg::POS_RESET : pos_r + 8'h01; // R1 R12
      quad_counter_pkg::ACT_DOWN:
        pos_nxt = atZero ? POS_MAX : pos_r - 8'h01; // R2 R12
      quad_counter_pkg::ACT_HOLD:
        pos_nxt = pos_r;
      default:
        pos_nxt = pos_r;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      pos_r <= quad_counter_pkg::POS_RESET;
    else
      pos_r <= pos_nxt;
  end

  // core clock runs at the board rate; the tick divider absorbs the difference
  assign channelZeroCaptureEvent = capA; // R10
  assign channelOneCaptureEvent = capB;
  assign widthA = widthA_r;
  assign widthB = widthB_r;
  assign positionCount = pos_r;

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  // a rising with b high counts up
  sequence s_upEdge;
    capA && !capB && levelB && !sampA_r && levelA && !atMax;
  endsequence

  // b rising with a high counts down
  sequence s_downEdge;
    capB && !capA && levelA && !sampB_r && levelB && !atZero;
  endsequence

  a_count_up: assert property (@(posedge clk) disable iff (!rstn) // R1
    s_upEdge |=> pos_r == $past(pos_r) + 8'h01)
    else $error("count did not rise on forward edge");

  a_count_down: assert property (@(posedge clk) disable iff (!rstn) // R2
    s_downEdge |=> pos_r == $past(pos_r) - 8'h01)
    else $error("count did not fall on reverse edge");

  a_both_edges: assert property (@(posedge clk) disable iff (!rstn) // R3
    (run_r && enable && $fell(levelA)) |-> ##1 channelZeroCaptureEvent == 1'b0 ##0
    $past(capA))
    else $error("falling edge not captured");

  a_width_capture: assert property (@(posedge clk) disable iff (!rstn) // R4
    capB |=> widthB_r == $past(cntB_r) && cntB_r == 16'h0000)
    else $error("width not captured on edge");

  a_tick_period: assert property (@(posedge clk) disable iff (!rstn) // R5
    prescaledTimerClock |=> !prescaledTimerClock [*8])
    else $error("timer tick too frequent");

  a_no_start_event: assert property (@(posedge clk) disable iff (!rstn) // R8
    !run_r |-> !channelZeroCaptureEvent && !channelOneCaptureEvent)
    else $error("capture raised at start");

  a_wrap_up: assert property (@(posedge clk) disable iff (!rstn) // R12
    (act == quad_counter_pkg::ACT_UP && atMax) |=> pos_r == 8'h00)
    else $error("count did not wrap to zero");

  a_wrap_down: assert property (@(posedge clk) disable iff (!rstn) // R12
    (act == quad_counter_pkg::ACT_DOWN && atZero) |=> pos_r == 8'hEF)
    else $error("count did not wrap to maximum");

  a_hold_idle: assert property (@(posedge clk) disable iff (!rstn) // R11
    !anyCap |=> $stable(pos_r))
    else $error("count moved without capture");

endmodule

// file: src/quad_counter_pkg.sv
package quad_counter_pkg;

  // ---------------------------------------------------------------
  // clocks
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned CORE_HZ = 20000000;
  // 9.77 kHz timer tick, expressed in millihertz
  localparam int unsigned TICK_MHZ = 9770000;
  // rounded to the nearest divisor; 64-bit math, clock times 1000 overflows 32 bits
  localparam int unsigned TICK_DIV =
    32'((longint'(CLK_HZ) * 1000 + TICK_MHZ / 2) / TICK_MHZ);
  localparam int unsigned DIV_W = 12;

  // ---------------------------------------------------------------
  // position counter
  // ---------------------------------------------------------------
  localparam int unsigned STEPS_PER_REV = 60;
  localparam int unsigned EDGES_PER_STEP = 4;
  localparam int unsigned MAX_COUNT_LIMIT = STEPS_PER_REV * EDGES_PER_STEP;
  localparam int unsigned POS_W = 8;
  localparam logic [POS_W-1:0] POS_RESET = 8'h00;

  // ---------------------------------------------------------------
  // noise filter
  // ---------------------------------------------------------------
  localparam int unsigned FILT_SAMPLES = 3;

  // count action chosen from the sampled phase levels
  typedef enum logic [1:0] {
    ACT_HOLD = 2'b00,
    ACT_UP   = 2'b01,
    ACT_DOWN = 2'b10
  } action_t;

endpackage

// file: src/phase_filter.sv
`timescale 1ns/1ps
module phase_filter
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // sampling tick
  input wire logic tick,
  // raw and filtered level
  input wire logic rawIn,
  output logic level
);

  // -----------------------------------------------------------------
  // sample shift register
  // -----------------------------------------------------------------
  // a level is accepted only after it stands for every sample in the window
  logic [quad_counter_pkg::FILT_SAMPLES-1:0] hist_r;
  logic level_r;
  wire allHigh = &hist_r;
  wire allLow = ~|hist_r;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      hist_r <= '0;
      level_r <= 1'b0;
    end
    else
    begin
      if (tick)
        hist_r <= {hist_r[quad_counter_pkg::FILT_SAMPLES-2:0], rawIn};
      if (allHigh)
        level_r <= 1'b1;
      else if (allLow)
        level_r <= 1'b0;
    end
  end

  assign level = level_r;

endmodule

// file: verif/encoder_model.sv
`timescale 1ns/1ps
module encoder_model
(
  // clock
  input wire logic clk,
  // step commands from the bench
  input wire logic toggleA,
  input wire logic toggleB,
  // encoder phases
  output logic phaseA,
  output logic phaseB
);
  // ---------------------------------------------------------------
  // phase generator
  // ---------------------------------------------------------------
  // phases move only on clk, so they reach the counter synchronous to it
  initial
  begin
    phaseA = 1'b0;
    phaseB = 1'b0;
  end

  always @(posedge clk)
  begin
    if (toggleA)
      phaseA <= ~phaseA;
    if (toggleB)
      phaseB <= ~phaseB;
  end
endmodule

// file: verif/two_phase_quadrature_counter_tb.sv
`timescale 1ns/1ps
module two_phase_quadrature_counter_tb;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam int TICK = quad_counter_pkg::TICK_DIV;
  localparam int LIM = quad_counter_pkg::MAX_COUNT_LIMIT;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic enable = 1'b0;
  logic toggleA = 1'b0;
  logic toggleB = 1'b0;
  logic phaseA;
  logic phaseB;
  logic evA;
  logic evB;
  logic [quad_counter_pkg::POS_W-1:0] positionCount;
  logic [15:0] widthA;
  logic [15:0] widthB;
  int err_total = 0;
  int check_count = 0;
  int pos = 0;
  int hits = 0;

  always #20 clk = ~clk;

  encoder_model enc
  (
    .clk(clk),
    .toggleA(toggleA),
    .toggleB(toggleB),
    .phaseA(phaseA),
    .phaseB(phaseB)
  );

  two_phase_quadrature_counter DUT
  (
    .clk(clk),
    .rstn(rstn),
    .phaseAInput(phaseA),
    .phaseBInput(phaseB),
    .enable(enable),
    .channelZeroCaptureEvent(evA),
    .channelOneCaptureEvent(evB),
    .widthA(widthA),
    .widthB(widthB),
    .positionCount(positionCount)
  );

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task finish_test();
    $display("mismatches %0d, comparisons %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask

  // inputs always change a fixed 2 ns after the rising edge
  task cyc();
    @(posedge clk);
    #2;
  endtask

  task quiet(input int n);
    hits = 0;
    repeat (n)
    begin
      cyc();
      if (evA !== 1'b0 || evB !== 1'b0)
        hits++;
    end
  endtask

  // one quadrature edge on A or B; waits for its capture, then the count
  task step(input logic onA, input int delta);
    int n;
    n = 0;
    toggleA = onA;
    toggleB = ~onA;
    cyc();
    toggleA = 1'b0;
    toggleB = 1'b0;
    while (evA !== 1'b1 && evB !== 1'b1 && n < 5 * TICK)
    begin
      cyc();
      n++;
    end
    if (n == 5 * TICK)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: no capture event", $time);
      finish_test();
    end
    pos = (pos + delta + LIM) % LIM;
    check({7'h00, evA}, {7'h00, onA});
    check({7'h00, evB}, {7'h00, ~onA});
    cyc();
    check(positionCount, 8'(pos));
    check({7'h00, evA | evB}, 8'h00);
  endtask

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clk);
    #2;
    rstn = 1'b1;
    check(positionCount, quad_counter_pkg::POS_RESET);
    cyc();
    enable = 1'b1;
    quiet(3 * TICK);
    check(8'(hits), 8'h00);
    // first down step from zero must wrap to the top of the range
    step(1'b1, -1);
    step(1'b0, -1);
    // back-to-back edges sit one filter window of ticks apart
    step(1'b0, 1);
    check(widthB[7:0], 8'(quad_counter_pkg::FILT_SAMPLES));
    // up step from the top must wrap to zero
    step(1'b1, 1);
    check(widthA[7:0], 8'(3 * quad_counter_pkg::FILT_SAMPLES));
    step(1'b0, 1);
    check(widthB[7:0], 8'(2 * quad_counter_pkg::FILT_SAMPLES));
    step(1'b1, 1);
    check(widthA[7:0], 8'(2 * quad_counter_pkg::FILT_SAMPLES));
    check(widthA[15:8] | widthB[15:8], 8'h00);
    // a low pulse on A shorter than one tick cannot win three samples
    toggleA = 1'b1;
    cyc();
    toggleA = 1'b0;
    repeat (TICK / 2) cyc();
    toggleA = 1'b1;
    cyc();
    toggleA = 1'b0;
    quiet(4 * TICK);
    check(8'(hits), 8'h00);
    check(positionCount, 8'(pos));
    finish_test();
  end
endmodule
